/* File: hw/timer_pkg.sv */
// How it works
// - Two 16-bit counter/timers behave like the classic 8051 pair.
// - Two more 16-bit auto-reload timers serve as general time bases.
// - Compatible timers: 13-bit, 16-bit, 8-bit reload; split mode on first only.
// - Auto-reload timers run as one 16-bit or two 8-bit reloading timers.
// - Compatible timer clock picked from five sources via select and scale bits.
// - Select bit set counts system clock, else the prescaled clock.
// - Auto-reload clock: system clock, system clock /12, or oscillator /8.
// - Counter operation counts each falling edge of the event input.
// - Events up to a quarter of system clock rate are all counted.
// - Overflows raise interrupt requests, except timer b's while timer a is in split mode.
// - 13-bit mode uses high byte and low five bits; wrap sets flag.
// - Outside split mode, counts only when run set and gate disabled or gate input active.
// - 8-bit reload: low byte wrap sets flag, reloads from high byte.
// - Split: high byte counts internal clock, run by b, sets b flag.
package timer_pkg;

    localparam int unsigned ADDR_W = 5;

    localparam logic [4:0] OFS_CTRL     = 5'h00;
    localparam logic [4:0] OFS_COUNT01  = 5'h04;
    localparam logic [4:0] OFS_ARCTRL   = 5'h08;
    localparam logic [4:0] OFS_ARCOUNT  = 5'h0c;
    localparam logic [4:0] OFS_ARRELOAD = 5'h10;
    localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h18;

    localparam logic [15:0] RST_CTRL    = 16'h0000;
    localparam logic [7:0]  RST_ARCTRL  = 8'h00;
    localparam logic [15:0] RST_COUNT16 = 16'h0000;
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;

    localparam int unsigned IRQ_W    = 6;
    localparam int unsigned IRQ_A    = 0;
    localparam int unsigned IRQ_B    = 1;
    localparam int unsigned IRQ_C_HI = 2;
    localparam int unsigned IRQ_C_LO = 3;
    localparam int unsigned IRQ_D_HI = 4;
    localparam int unsigned IRQ_D_LO = 5;

    localparam int unsigned PRE_DIV4  = 4;
    localparam int unsigned PRE_DIV12 = 12;
    localparam int unsigned PRE_DIV48 = 48;
    localparam int unsigned EXT_DIV   = 8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_13BIT, MODE_16BIT, MODE_8BIT_RELOAD, MODE_SPLIT
    } ct_mode_t;

    typedef enum logic [1:0] {
        SCALE_DIV12, SCALE_DIV4, SCALE_DIV48, SCALE_EXT8
    } prescale_t;

    typedef enum logic [1:0] {
        AR_SYSCLK, AR_DIV12, AR_EXT8, AR_OFF
    } ar_clk_t;

    typedef struct packed {
        logic     gate_pol_b;
        logic     gate_pol_a;
        logic     prescale_select_hi;
        logic     prescale_select_lo;
        logic     timer1_sysclk_select;
        logic     timer0_sysclk_select;
        ct_mode_t mode_b;
        ct_mode_t mode_a;
        logic     count_ext_b;
        logic     count_ext_a;
        logic     gate_enable_b;
        logic     gate_enable_a;
        logic     run_bit_b;
        logic     run_bit_a;
    } ct_ctrl_t;

    typedef struct packed {
        ar_clk_t clk_d;
        logic    split_d;
        logic    run_d;
        ar_clk_t clk_c;
        logic    split_c;
        logic    run_c;
    } ar_ctrl_t;

endpackage : timer_pkg

/* File: hw/pin_sync.sv */
module pin_sync (
    input  wire logic aclk,    // System clock
    input  wire logic aresetn, // Synchronous reset, active low
    input  wire logic pin,     // Asynchronous input pin
    output logic      level,   // Settled level
    output logic      fall,    // One-cycle pulse, high-to-low
    output logic      rise     // One-cycle pulse, low-to-high
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic agree;

    assign agree = (s2_r == s3_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= 1'h0;
            s2_r <= 1'h0;
            s3_r <= 1'h0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Two-cycle level hold from the source makes the agree test safe
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level <= 1'h0;
            fall  <= 1'h0;
            rise  <= 1'h0;
        end else begin
            fall <= level & agree & ~s3_r;
            rise <= ~level & agree & s3_r;
            if (agree) begin
                level <= s3_r;
            end
        end
    end

endmodule : pin_sync

/* File: hw/four_counter_timer_unit.sv */
module four_counter_timer_unit #(
    parameter int unsigned ADDR_W = timer_pkg::ADDR_W // Bus address width
) (
    input  wire logic              aclk,    // 200 MHz system clock
    input  wire logic              aresetn, // Synchronous reset, low
    input  wire logic [ADDR_W-1:0] awaddr,  // Write address
    input  wire logic              awvalid, // Write address valid
    output logic                   awready, // Write address ready
    input  wire logic [31:0]       wdata,   // Write data
    input  wire logic [3:0]        wstrb,   // Write byte strobes
    input  wire logic              wvalid,  // Write data valid
    output logic                   wready,  // Write data ready
    output logic [1:0]             bresp,   // Write response
    output logic                   bvalid,  // Write response valid
    input  wire logic              bready,  // Write response ready
    input  wire logic [ADDR_W-1:0] araddr,  // Read address
    input  wire logic              arvalid, // Read address valid
    output logic                   arready, // Read address ready
    output logic [31:0]            rdata,   // Read data
    output logic [1:0]             rresp,   // Read response
    output logic                   rvalid,  // Read data valid
    input  wire logic              rready,  // Read data ready
    input  wire logic event_input_a,         // Event pin, timer a
    input  wire logic event_input_b,         // Event pin, timer b
    input  wire logic external_gate_input_a, // Gate pin, timer a
    input  wire logic external_gate_input_b, // Gate pin, timer b
    input  wire logic ext_osc,               // External oscillator
    output logic      irq                    // Level interrupt, high
);
    import timer_pkg::*;

    initial begin
        if (ADDR_W < 5) begin
            $error("ADDR_W too small for the register map");
        end
    end

    ct_ctrl_t          ctl_r;
    ar_ctrl_t          arc_r;
    logic [15:0]       cnt_a_r, cnt_a_nxt, cnt_b_r, cnt_b_nxt;
    logic [31:0]       reload_r;
    logic [IRQ_W-1:0]  stat_r, mask_r, set_v;
    logic [1:0][15:0]  ar_cnt;
    logic [1:0]        ar_hi, ar_lo;

    // Pin synchronisers: event a, event b, gate a, gate b, oscillator
    logic [4:0] pin_in, pin_lvl, pin_fall, pin_rise;
    assign pin_in = {ext_osc, external_gate_input_b, external_gate_input_a,
                     event_input_b, event_input_a};
    for (genvar k = 0; k < 5; k++) begin : g_sync
        pin_sync u_sync (
            .aclk    (aclk),
            .aresetn (aresetn),
            .pin     (pin_in[k]),
            .level   (pin_lvl[k]),
            .fall    (pin_fall[k]),
            .rise    (pin_rise[k])
        );
    end

    // AXI4-Lite slave
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;
    logic              aw_hold_r, w_hold_r, do_write;

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a[ADDR_W-1:2] <= OFS_IRQ_MASK[4:2]) && (a[1:0] == 2'h0);
    endfunction : mapped

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        for (int b = 0; b < 4; b++) begin
            merge[8*b +: 8] = st[b] ? nw[8*b +: 8] : old[8*b +: 8];
        end
    endfunction : merge

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [4:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction : hit

    assign awready  = ~aw_hold_r & ~bvalid;
    assign wready   = ~w_hold_r & ~bvalid;
    assign arready  = ~rvalid;
    assign do_write = aw_hold_r & w_hold_r & ~bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'h0;
            w_hold_r  <= 1'h0;
            aw_addr_r <= '0;
            w_data_r  <= RST_WORD;
            w_strb_r  <= 4'h0;
            bvalid    <= 1'h0;
            bresp     <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_hold_r <= 1'h1;
                aw_addr_r <= awaddr;
            end
            if (wvalid && wready) begin
                w_hold_r <= 1'h1;
                w_data_r <= wdata;
                w_strb_r <= wstrb;
            end
            if (do_write) begin
                aw_hold_r <= 1'h0;
                w_hold_r  <= 1'h0;
                bvalid    <= 1'h1;
                bresp     <= mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'h0;
            end
        end
    end

    logic wr_ctrl, wr_cnt01, wr_arctrl, wr_arcnt, wr_reload, wr_stat, wr_mask;
    assign wr_ctrl   = do_write & hit(aw_addr_r, OFS_CTRL);
    assign wr_cnt01  = do_write & hit(aw_addr_r, OFS_COUNT01);
    assign wr_arctrl = do_write & hit(aw_addr_r, OFS_ARCTRL);
    assign wr_arcnt  = do_write & hit(aw_addr_r, OFS_ARCOUNT);
    assign wr_reload = do_write & hit(aw_addr_r, OFS_ARRELOAD);
    assign wr_stat   = do_write & hit(aw_addr_r, OFS_IRQ_STAT);
    assign wr_mask   = do_write & hit(aw_addr_r, OFS_IRQ_MASK);

    logic [31:0] cnt01_w, arcnt_w, wm_cnt01, wm_arcnt;
    assign cnt01_w  = {cnt_b_r, cnt_a_r};
    assign arcnt_w  = {ar_cnt[1], ar_cnt[0]};
    assign wm_cnt01 = merge(cnt01_w, w_data_r, w_strb_r);
    assign wm_arcnt = merge(arcnt_w, w_data_r, w_strb_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_r    <= ct_ctrl_t'(RST_CTRL);
            arc_r    <= ar_ctrl_t'(RST_ARCTRL);
            reload_r <= RST_WORD;
            mask_r   <= '0;
        end else begin
            if (wr_ctrl) begin
                ctl_r <= ct_ctrl_t'(16'(merge({16'h0000, ctl_r}, w_data_r,
                                              w_strb_r)));
            end
            if (wr_arctrl) begin
                arc_r <= ar_ctrl_t'(w_strb_r[0] ? w_data_r[7:0] : arc_r);
            end
            if (wr_reload) begin
                reload_r <= merge(reload_r, w_data_r, w_strb_r);
            end
            if (wr_mask && w_strb_r[0]) begin
                mask_r <= w_data_r[IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'h0;
            rdata  <= RST_WORD;
            rresp  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'h1;
            rresp  <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            case (araddr[ADDR_W-1:2])
                OFS_CTRL[4:2]:     rdata <= {16'h0000, ctl_r};
                OFS_COUNT01[4:2]:  rdata <= cnt01_w;
                OFS_ARCTRL[4:2]:   rdata <= {24'h000000, arc_r};
                OFS_ARCOUNT[4:2]:  rdata <= arcnt_w;
                OFS_ARRELOAD[4:2]: rdata <= reload_r;
                OFS_IRQ_STAT[4:2]: rdata <= {26'h0, stat_r};
                OFS_IRQ_MASK[4:2]: rdata <= {26'h0, mask_r};
                default:           rdata <= RST_WORD;
            endcase
        end else if (rready) begin
            rvalid <= 1'h0;
        end
    end

    // Time bases: /4 and /48 share one counter, /12 runs apart
    logic [5:0] cnt48_r;
    logic [3:0] cnt12_r;
    logic [2:0] ext_r;
    logic       tick4, tick12, tick48, tick_ext, pre_tick;
    assign tick4    = cnt48_r[1:0] == 2'(PRE_DIV4 - 1);
    assign tick48   = cnt48_r == 6'(PRE_DIV48 - 1);
    assign tick12   = cnt12_r == 4'(PRE_DIV12 - 1);
    assign tick_ext = pin_rise[4] & (ext_r == 3'(EXT_DIV - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt48_r <= 6'h00;
            cnt12_r <= 4'h0;
            ext_r   <= 3'h0;
        end else begin
            cnt48_r <= tick48 ? 6'h00 : cnt48_r + 6'h01;
            cnt12_r <= tick12 ? 4'h0 : cnt12_r + 4'h1;
            if (pin_rise[4]) begin
                ext_r <= ext_r + 3'h1;
            end
        end
    end

    always_comb begin
        case (prescale_t'({ctl_r.prescale_select_hi, ctl_r.prescale_select_lo}))
            SCALE_DIV12: pre_tick = tick12;
            SCALE_DIV4:  pre_tick = tick4;
            SCALE_DIV48: pre_tick = tick48;
            SCALE_EXT8:  pre_tick = tick_ext;
            default:     pre_tick = 1'h0;
        endcase
    end

    // Compatible counter/timers a and b
    function automatic logic [16:0] step(input ct_mode_t m,
                                         input logic [15:0] c);
        logic [13:0] v13;
        logic [8:0]  v8;
        v13 = {1'h0, c[15:8], c[4:0]} + 14'h0001;
        v8  = {1'h0, c[7:0]} + 9'h001;
        case (m)
            MODE_13BIT: step = {v13[13], v13[12:5], c[7:5], v13[4:0]};
            MODE_16BIT: step = {1'h0, c} + 17'h00001;
            MODE_8BIT_RELOAD: step = v8[8] ? {1'h1, c[15:8], c[15:8]}
                                           : {1'h0, c[15:8], v8[7:0]};
            default: step = {v8[8], c[15:8], v8[7:0]};
        endcase
    endfunction : step

    logic gate_ok_a, gate_ok_b, int_tick_a, int_tick_b, tick_a, tick_b;
    logic split, en_a, en_ah, en_b, ovf_a, ovf_ah, ovf_b;
    logic [16:0] step_a, step_b;

    assign gate_ok_a  = ~ctl_r.gate_enable_a
                        | (pin_lvl[2] == ctl_r.gate_pol_a);
    assign gate_ok_b  = ~ctl_r.gate_enable_b
                        | (pin_lvl[3] == ctl_r.gate_pol_b);
    assign int_tick_a = ctl_r.timer0_sysclk_select | pre_tick;
    assign int_tick_b = ctl_r.timer1_sysclk_select | pre_tick;
    assign tick_a = ctl_r.count_ext_a ? pin_fall[0] : int_tick_a;
    assign tick_b = ctl_r.count_ext_b ? pin_fall[1] : int_tick_b;
    assign split  = ctl_r.mode_a == MODE_SPLIT;
    assign en_a   = ctl_r.run_bit_a & gate_ok_a & tick_a;
    assign en_ah  = split & ctl_r.run_bit_b & int_tick_a;
    // While a is split, b runs on internal clock and is stopped by mode
    assign en_b   = (ctl_r.mode_b != MODE_SPLIT)
                    & (split ? int_tick_b
                             : ctl_r.run_bit_b & gate_ok_b & tick_b);
    assign step_a = step(ctl_r.mode_a, cnt_a_r);
    assign step_b = step(ctl_r.mode_b, cnt_b_r);

    always_comb begin
        cnt_a_nxt = cnt_a_r;
        ovf_a     = 1'h0;
        ovf_ah    = 1'h0;
        if (en_a) begin
            cnt_a_nxt = step_a[15:0];
            ovf_a     = step_a[16];
        end
        if (en_ah) begin
            {ovf_ah, cnt_a_nxt[15:8]} = {1'h0, cnt_a_r[15:8]} + 9'h001;
        end
    end

    assign cnt_b_nxt = en_b ? step_b[15:0] : cnt_b_r;
    assign ovf_b     = en_b & step_b[16] & ~split;

    // Software write wins over counting in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_a_r <= RST_COUNT16;
            cnt_b_r <= RST_COUNT16;
        end else if (wr_cnt01) begin
            cnt_a_r <= wm_cnt01[15:0];
            cnt_b_r <= wm_cnt01[31:16];
        end else begin
            cnt_a_r <= cnt_a_nxt;
            cnt_b_r <= cnt_b_nxt;
        end
    end

    // Auto-reload timers c and d
    logic [1:0]      ar_run, ar_split;
    ar_clk_t [1:0]   ar_clk;
    assign ar_run   = {arc_r.run_d, arc_r.run_c};
    assign ar_split = {arc_r.split_d, arc_r.split_c};
    assign ar_clk[0] = arc_r.clk_c;
    assign ar_clk[1] = arc_r.clk_d;

    for (genvar i = 0; i < 2; i++) begin : g_ar
        logic [15:0] cnt_r, cnt_nxt, rl;
        logic        tk, en;
        assign rl = reload_r[16*i +: 16];
        always_comb begin
            case (ar_clk[i])
                AR_SYSCLK: tk = 1'h1;
                AR_DIV12:  tk = tick12;
                AR_EXT8:   tk = tick_ext;
                default:   tk = 1'h0;
            endcase
        end
        assign en = ar_run[i] & tk;
        always_comb begin
            cnt_nxt  = cnt_r;
            ar_hi[i] = 1'h0;
            ar_lo[i] = 1'h0;
            if (en && !ar_split[i]) begin
                if (cnt_r == 16'hffff) begin
                    cnt_nxt  = rl;
                    ar_hi[i] = 1'h1;
                end else begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
            end else if (en) begin
                for (int h = 0; h < 2; h++) begin
                    if (cnt_r[8*h +: 8] == 8'hff) begin
                        cnt_nxt[8*h +: 8] = rl[8*h +: 8];
                    end else begin
                        cnt_nxt[8*h +: 8] = cnt_r[8*h +: 8] + 8'h01;
                    end
                end
                ar_hi[i] = cnt_r[15:8] == 8'hff;
                ar_lo[i] = cnt_r[7:0] == 8'hff;
            end
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cnt_r <= RST_COUNT16;
            end else if (wr_arcnt) begin
                cnt_r <= wm_arcnt[16*i +: 16];
            end else begin
                cnt_r <= cnt_nxt;
            end
        end
        assign ar_cnt[i] = cnt_r;
    end

    // Sticky status; a new event outranks a write-one-to-clear
    always_comb begin
        set_v           = '0;
        set_v[IRQ_A]    = ovf_a;
        set_v[IRQ_B]    = ovf_b | ovf_ah;
        set_v[IRQ_C_HI] = ar_hi[0];
        set_v[IRQ_C_LO] = ar_lo[0];
        set_v[IRQ_D_HI] = ar_hi[1];
        set_v[IRQ_D_LO] = ar_lo[1];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_r <= '0;
        end else begin
            stat_r <= (stat_r & ~((wr_stat && w_strb_r[0])
                                  ? w_data_r[IRQ_W-1:0] : '0)) | set_v;
        end
    end

    assign irq = |(stat_r & mask_r);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_stop_holds;
        !ctl_r.run_bit_a && !split && !wr_cnt01 |=> $stable(cnt_a_r);
    endproperty
    a_stop_holds: assert property (p_stop_holds)
        else $error("timer a moved while stopped");

    property p_wrap13;
        ctl_r.mode_a == MODE_13BIT && en_a && !wr_cnt01
        && cnt_a_r[15:8] == 8'hff && cnt_a_r[4:0] == 5'h1f
        |=> cnt_a_r[15:8] == 8'h00 && cnt_a_r[4:0] == 5'h00
            && stat_r[IRQ_A];
    endproperty
    a_wrap13: assert property (p_wrap13)
        else $error("13-bit wrap wrong");

    property p_reload8;
        ctl_r.mode_a == MODE_8BIT_RELOAD && en_a && !wr_cnt01
        && cnt_a_r[7:0] == 8'hff
        |=> cnt_a_r[7:0] == $past(cnt_a_r[15:8])
            && $stable(cnt_a_r[15:8]) && stat_r[IRQ_A];
    endproperty
    a_reload8: assert property (p_reload8)
        else $error("8-bit reload wrong");

    property p_split_hi;
        split && ctl_r.run_bit_b && int_tick_a && !wr_cnt01
        && cnt_a_r[15:8] == 8'hff |=> stat_r[IRQ_B] && cnt_a_r[15:8] == 8'h00;
    endproperty
    a_split_hi: assert property (p_split_hi)
        else $error("split high byte overflow wrong");

    property p_ar_reload;
        ar_run[0] && !ar_split[0] && ar_clk[0] == AR_SYSCLK && !wr_arcnt
        && ar_cnt[0] == 16'hffff && !wr_reload
        |=> ar_cnt[0] == reload_r[15:0] && stat_r[IRQ_C_HI];
    endproperty
    a_ar_reload: assert property (p_ar_reload)
        else $error("auto-reload overflow wrong");

    property p_event_count;
        ctl_r.count_ext_a && ctl_r.mode_a == MODE_16BIT && ctl_r.run_bit_a
        && !ctl_r.gate_enable_a && pin_fall[0] && !wr_cnt01
        |=> cnt_a_r == $past(cnt_a_r) + 16'h0001;
    endproperty
    a_event_count: assert property (p_event_count)
        else $error("event edge not counted");

    property p_sysclk_run;
        (!ctl_r.count_ext_b && ctl_r.timer1_sysclk_select && !split
         && ctl_r.mode_b == MODE_16BIT && ctl_r.run_bit_b
         && !ctl_r.gate_enable_b && !wr_cnt01) [*2]
        |=> cnt_b_r == $past(cnt_b_r, 2) + 16'h0002;
    endproperty
    a_sysclk_run: assert property (p_sysclk_run)
        else $error("system clock count rate wrong");

    property p_div12;
        ar_clk[1] == AR_DIV12 && !tick12 && !wr_arcnt
        |=> $stable(ar_cnt[1]);
    endproperty
    a_div12: assert property (p_div12)
        else $error("divide by 12 clock too fast");

    property p_sticky_set_wins;
        set_v[IRQ_A] |=> stat_r[IRQ_A] && (!mask_r[IRQ_A] || irq);
    endproperty
    a_sticky_set_wins: assert property (p_sticky_set_wins)
        else $error("overflow flag lost");

    property p_bresp_time;
        awvalid && awready && wvalid && wready |-> ##2 bvalid;
    endproperty
    a_bresp_time: assert property (p_bresp_time)
        else $error("write response late");

endmodule : four_counter_timer_unit

/* File: verification/event_source.sv */
module event_source (
    input  wire logic aclk,   // System clock
    output logic      ev_a,   // Event pin, timer a
    output logic      ev_b,   // Event pin, timer b
    output logic      gate_a, // Gate pin, timer a
    output logic      gate_b, // Gate pin, timer b
    output logic      osc     // Free-running oscillator
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ev_a = 1'b1;
        ev_b = 1'b1;
        gate_a = 1'b0;
        gate_b = 1'b0;
        osc = 1'b0;
    end
    // Slow enough that each level survives the pin synchroniser
    always #13 osc = ~osc;
    // Each level held two cycles: the fastest legal rate
    task automatic pulse_a(input int n);
        repeat (2 * n) begin
            @(posedge aclk);
            ev_a <= ~ev_a;
            @(posedge aclk);
        end
    endtask : pulse_a
    task automatic set_gate(input logic v);
        @(posedge aclk);
        gate_a <= v;
    endtask : set_gate
endmodule : event_source

/* File: verification/test_four_counter_timer_unit.sv */
module test_four_counter_timer_unit;
    import timer_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 0, aresetn = 0, irq, ev_a, ev_b, gate_a, gate_b, osc;
    logic [4:0]  awaddr = 0, araddr = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 0, rdata, rd_s;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp, br_s, rr_s;
    logic [4:0]  snap;
    int          n_fail = 0, num_checks = 0;
    always #2.5 aclk = ~aclk;
    // Settled outputs as the next rising edge will see them
    always @(negedge aclk) begin
        snap <= {awready, wready, bvalid, arready, rvalid};
        {rd_s, br_s, rr_s} <= {rdata, bresp, rresp};
    end
    four_counter_timer_unit dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .event_input_a(ev_a), .event_input_b(ev_b),
        .external_gate_input_a(gate_a), .external_gate_input_b(gate_b),
        .ext_osc(osc), .irq(irq));
    event_source src (.aclk(aclk), .ev_a(ev_a), .ev_b(ev_b),
        .gate_a(gate_a), .gate_b(gate_b), .osc(osc));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (snap[4]) awvalid <= 1'b0;
            if (snap[3]) wvalid <= 1'b0;
            if (snap[2]) break;
        end
        bready <= 1'b0;
        check({30'h0, br_s}, {30'h0, RESP_OKAY});
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [31:0] e,
                      input logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (snap[1]) arvalid <= 1'b0;
            if (snap[0]) break;
        end
        rready <= 1'b0;
        check(rd_s, e);
        check({30'h0, rr_s}, {30'h0, r});
    endtask : rd
    task automatic events(input int n);
        src.pulse_a(n);
        repeat (8) @(posedge aclk);
    endtask : events
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    initial begin
        #50us;
        n_fail++;
        close_out();
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(5'h1c, RST_WORD, RESP_SLVERR);
        rd(OFS_CTRL, RST_WORD, RESP_OKAY);
        $display("reset test done");
        wr(OFS_CTRL, 32'h0000_0051);
        events(5);
        rd(OFS_COUNT01, 32'h0000_0005, RESP_OKAY);
        $display("event count test done");
        wr(OFS_CTRL, 32'h0000_0011);
        wr(OFS_COUNT01, 32'h0000_ff1f);
        wr(OFS_IRQ_MASK, 32'h0000_0001);
        events(1);
        rd(OFS_COUNT01, RST_WORD, RESP_OKAY);
        rd(OFS_IRQ_STAT, 32'h0000_0001, RESP_OKAY);
        check({31'h0, irq}, 32'h0000_0001);
        wr(OFS_IRQ_STAT, 32'h0000_0001);
        check({31'h0, irq}, RST_WORD);
        $display("13-bit wrap test done");
        wr(OFS_COUNT01, 32'h0000_40ff);
        wr(OFS_CTRL, 32'h0000_0091);
        events(1);
        rd(OFS_COUNT01, 32'h0000_4040, RESP_OKAY);
        rd(OFS_IRQ_STAT, 32'h0000_0001, RESP_OKAY);
        $display("8-bit reload test done");
        wr(OFS_CTRL, RST_WORD);
        wr(OFS_COUNT01, RST_WORD);
        wr(OFS_CTRL, 32'h0000_4055);
        events(2);
        rd(OFS_COUNT01, RST_WORD, RESP_OKAY);
        src.set_gate(1'b1);
        events(3);
        rd(OFS_COUNT01, 32'h0000_0003, RESP_OKAY);
        $display("gate test done");
        wr(OFS_CTRL, RST_WORD);
        wr(OFS_COUNT01, 32'hfffe_0000);
        wr(OFS_ARCOUNT, 32'h0000_fffe);
        wr(OFS_ARRELOAD, 32'h0000_1234);
        wr(OFS_IRQ_STAT, 32'h0000_003f);
        wr(OFS_CTRL, 32'h0000_0902);
        wr(OFS_ARCTRL, 32'h0000_0051);
        repeat (4) @(posedge aclk);
        rd(OFS_IRQ_STAT, 32'h0000_0006, RESP_OKAY);
        $display("auto-reload test done");
        wr(OFS_COUNT01, 32'h0000_fe00);
        wr(OFS_IRQ_STAT, 32'h0000_003f);
        wr(OFS_CTRL, 32'h0000_07c2);
        repeat (4) @(posedge aclk);
        rd(OFS_IRQ_STAT, 32'h0000_0002, RESP_OKAY);
        $display("split test done");
        close_out();
    end
endmodule : test_four_counter_timer_unit
